/* design/cgo_top.v */
// clock output enable control: formats, enables, strap pin and page load
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cgo_defines.vh"

module cgo_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        frac_divider_zero,
  input  wire        frac_divider_one,
  input  wire        pair_one_src,
  input  wire        pair_two_src,
  input  wire        clocks_ready,
  input  wire        enable_pin,
  input  wire        addr_pin,
  input  wire [1:0]  page_select_pins,
  input  wire        aux_pin_in,
  output reg         aux_pin_out,
  output reg         aux_pin_oe,
  output reg         clock_out_a,
  output reg         clock_out_a_oe,
  output reg         clock_out_b,
  output reg         clock_out_b_oe,
  output reg         clock_out_c,
  output reg         clock_out_c_oe,
  output reg         clock_out_d,
  output reg         clock_out_d_oe,
  output reg         enable_pin_pullup,
  output reg         enable_pin_pulldown,
  output reg         addr_pin_pullup,
  output reg         addr_pin_pulldown,
  output reg         ssc_enable,
  output reg  [2:0]  ssc_config
);

  localparam [3:0] ST_SETTLE = 4'b0001;
  localparam [3:0] ST_LATCH  = 4'b0010;
  localparam [3:0] ST_LOAD   = 4'b0100;
  localparam [3:0] ST_RUN    = 4'b1000;

  // ************************************************************
  // helpers
  // ************************************************************
  function fmt_on;
    input [2:0] f;
    input       second;
    begin
      fmt_on = (f == `CGO_FMT_ANTI) | (f == `CGO_FMT_SAME) |
               (second ? (f == `CGO_FMT_B_ONLY) : (f == `CGO_FMT_A_ONLY));
    end
  endfunction

  function pin_on;
    input lvl;
    input pol;
    begin
      pin_on = pol ? ~lvl : lvl;
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg [5:0]  sync1_reg;
  reg [5:0]  sync2_reg;
  reg [3:0]  state_reg;
  reg [1:0]  settle_reg;
  reg        strap_reg;
  reg [1:0]  page_reg;
  reg        one_off_reg;
  reg        two_off_reg;
  reg        pol_reg;
  reg        one_en_reg;
  reg        two_en_reg;
  reg [1:0]  func_reg;
  reg        split_reg;
  reg [2:0]  fmt_one_reg;
  reg [2:0]  fmt_two_reg;
  reg        aux_src_reg;
  reg [1:0]  aux_div_reg;
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg [7:0]  addr_reg;
  reg        gate_a_reg;
  reg        gate_b_reg;
  reg        gate_c_reg;
  reg        gate_d_reg;
  reg        fod_prev_reg;
  reg [2:0]  aux_cnt_reg;
  reg [31:0] rd_next;

  wire run      = state_reg[3];
  wire en_lvl   = sync2_reg[0];
  wire addr_lvl = sync2_reg[1];
  wire take     = hsel & htrans[1] & hready;
  wire inv_one  = (fmt_one_reg == `CGO_FMT_ANTI);
  wire inv_two  = (fmt_two_reg == `CGO_FMT_ANTI);
  wire want_one = run & one_en_reg & pin_on(en_lvl, pol_reg);
  wire want_two = run & two_en_reg &
                  pin_on(split_reg ? addr_lvl : en_lvl, pol_reg);
  wire fod      = aux_src_reg ? frac_divider_one : frac_divider_zero;
  wire aux_clk  = (aux_div_reg == `CGO_DIV_2) ? aux_cnt_reg[0] :
                  (aux_div_reg == `CGO_DIV_4) ? aux_cnt_reg[1] : aux_cnt_reg[2];

  // ************************************************************
  // pin synchronisers and start-up sequence
  // ************************************************************
  // every pin passes two flops; only the second stage is read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {page_select_pins, aux_pin_in, 1'b0, addr_pin, enable_pin};
      sync2_reg <= sync1_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg  <= ST_SETTLE;
      settle_reg <= 2'h0;
      strap_reg  <= 1'b0;
      page_reg   <= 2'h0;
    end else begin
      case (state_reg)
        ST_SETTLE: begin
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == `CGO_SETTLE) begin
            state_reg <= ST_LATCH;
          end
        end
        ST_LATCH: begin
          strap_reg <= sync2_reg[3];
          page_reg  <= sync2_reg[3] ? sync2_reg[5:4] : 2'h0;
          state_reg <= ST_LOAD;
        end
        ST_LOAD: state_reg <= ST_RUN;
        ST_RUN:  state_reg <= ST_RUN;
        default: state_reg <= ST_SETTLE;
      endcase
    end
  end

  // ************************************************************
  // bus slave and configuration registers
  // ************************************************************
  // reads take one wait state so a read right after a write sees it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      hrdata      <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= take & hwrite & (hsize == 3'h2);
      rd_pend_reg <= take & ~hwrite;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout <= 1'b1;
        hrdata    <= rd_next;
      end
    end
  end

  always @* begin
    rd_next = 32'h0000_0000;
    case (addr_reg)
      `CGO_OFF_OFFSTATE: begin
        rd_next[`CGO_B_ONE_OFF] = one_off_reg;
        rd_next[`CGO_B_TWO_OFF] = two_off_reg;
      end
      `CGO_OFF_ENCTRL: begin
        rd_next[`CGO_B_POL]                     = pol_reg;
        rd_next[`CGO_B_ONE_EN]                  = one_en_reg;
        rd_next[`CGO_B_TWO_EN]                  = two_en_reg;
        rd_next[`CGO_B_FUNC_HI:`CGO_B_FUNC_LO]  = func_reg;
      end
      `CGO_OFF_SPLIT: rd_next[`CGO_B_SPLIT] = split_reg;
      `CGO_OFF_FORMAT: begin
        rd_next[`CGO_B_F1_HI:`CGO_B_F1_LO]         = fmt_one_reg;
        rd_next[`CGO_B_F2_HI:`CGO_B_F2_LO]         = fmt_two_reg;
        rd_next[`CGO_B_AUXSRC]                     = aux_src_reg;
        rd_next[`CGO_B_AUXDIV_HI:`CGO_B_AUXDIV_LO] = aux_div_reg;
        rd_next[`CGO_B_SSCEN]                      = ssc_enable;
        rd_next[`CGO_B_SSCCFG_HI:`CGO_B_SSCCFG_LO] = ssc_config;
      end
      `CGO_OFF_STATUS: begin
        rd_next[5:0] = {gate_c_reg | gate_d_reg, gate_a_reg | gate_b_reg,
                        run, page_reg, strap_reg};
      end
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // page load wins over a bus write landing in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      one_off_reg <= `CGO_DEF_OFF;
      two_off_reg <= `CGO_DEF_OFF;
      pol_reg     <= `CGO_RST_POL;
      one_en_reg  <= `CGO_DEF_EN;
      two_en_reg  <= `CGO_DEF_EN;
      func_reg    <= `CGO_RST_FUNC;
      split_reg   <= `CGO_DEF_SPLIT;
      fmt_one_reg <= `CGO_DEF_FMT;
      fmt_two_reg <= `CGO_DEF_FMT;
      aux_src_reg <= `CGO_DEF_AUXSRC;
      aux_div_reg <= `CGO_DEF_AUXDIV;
      ssc_enable  <= `CGO_SSC_EN_P0;
      ssc_config  <= `CGO_SSC_CFG_P0;
    end else if (state_reg == ST_LOAD) begin
      one_off_reg <= `CGO_DEF_OFF;
      two_off_reg <= `CGO_DEF_OFF;
      one_en_reg  <= `CGO_DEF_EN;
      two_en_reg  <= `CGO_DEF_EN;
      fmt_one_reg <= `CGO_DEF_FMT;
      fmt_two_reg <= `CGO_DEF_FMT;
      func_reg    <= `CGO_RST_FUNC;
      aux_src_reg <= `CGO_DEF_AUXSRC;
      aux_div_reg <= `CGO_DEF_AUXDIV;
      split_reg   <= `CGO_DEF_SPLIT;
      ssc_enable  <= (page_reg == 2'h0) ? `CGO_SSC_EN_P0 : `CGO_SSC_EN_PX;
      case (page_reg)
        2'h0:    ssc_config <= `CGO_SSC_CFG_P0;
        2'h1:    ssc_config <= `CGO_SSC_CFG_P1;
        2'h2:    ssc_config <= `CGO_SSC_CFG_P2;
        default: ssc_config <= `CGO_SSC_CFG_P3;
      endcase
    end else if (wr_pend_reg) begin
      case (addr_reg)
        `CGO_OFF_OFFSTATE: begin
          one_off_reg <= hwdata[`CGO_B_ONE_OFF];
          two_off_reg <= hwdata[`CGO_B_TWO_OFF];
        end
        `CGO_OFF_ENCTRL: begin
          pol_reg    <= hwdata[`CGO_B_POL];
          one_en_reg <= hwdata[`CGO_B_ONE_EN];
          two_en_reg <= hwdata[`CGO_B_TWO_EN];
          func_reg   <= hwdata[`CGO_B_FUNC_HI:`CGO_B_FUNC_LO];
        end
        `CGO_OFF_SPLIT: split_reg <= hwdata[`CGO_B_SPLIT];
        `CGO_OFF_FORMAT: begin
          fmt_one_reg <= hwdata[`CGO_B_F1_HI:`CGO_B_F1_LO];
          fmt_two_reg <= hwdata[`CGO_B_F2_HI:`CGO_B_F2_LO];
          aux_src_reg <= hwdata[`CGO_B_AUXSRC];
          aux_div_reg <= hwdata[`CGO_B_AUXDIV_HI:`CGO_B_AUXDIV_LO];
          ssc_enable  <= hwdata[`CGO_B_SSCEN];
          ssc_config  <= hwdata[`CGO_B_SSCCFG_HI:`CGO_B_SSCCFG_LO];
        end
        default: ssc_enable <= ssc_enable;
      endcase
    end
  end

  // ************************************************************
  // glitch-free output gating
  // ************************************************************
  // each gate moves only while its own output level is low, so a
  // started high phase always completes; reserved formats stay off
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_a_reg <= 1'b0;
      gate_b_reg <= 1'b0;
      gate_c_reg <= 1'b0;
      gate_d_reg <= 1'b0;
    end else begin
      if (!pair_one_src) begin
        gate_a_reg <= want_one & fmt_on(fmt_one_reg, 1'b0);
      end
      if (!(pair_one_src ^ inv_one)) begin
        gate_b_reg <= want_one & fmt_on(fmt_one_reg, 1'b1);
      end
      if (!pair_two_src) begin
        gate_c_reg <= want_two & fmt_on(fmt_two_reg, 1'b0);
      end
      if (!(pair_two_src ^ inv_two)) begin
        gate_d_reg <= want_two & fmt_on(fmt_two_reg, 1'b1);
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_out_a    <= 1'b0;
      clock_out_b    <= 1'b0;
      clock_out_c    <= 1'b0;
      clock_out_d    <= 1'b0;
      clock_out_a_oe <= 1'b1;
      clock_out_b_oe <= 1'b1;
      clock_out_c_oe <= 1'b1;
      clock_out_d_oe <= 1'b1;
    end else begin
      clock_out_a    <= gate_a_reg & pair_one_src;
      clock_out_b    <= gate_b_reg & (pair_one_src ^ inv_one);
      clock_out_c    <= gate_c_reg & pair_two_src;
      clock_out_d    <= gate_d_reg & (pair_two_src ^ inv_two);
      clock_out_a_oe <= gate_a_reg | ~one_off_reg;
      clock_out_b_oe <= gate_b_reg | ~one_off_reg;
      clock_out_c_oe <= gate_c_reg | ~two_off_reg;
      clock_out_d_oe <= gate_d_reg | ~two_off_reg;
    end
  end

  // ************************************************************
  // strap pin: auxiliary clock, valid flag, low or tri-state
  // ************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fod_prev_reg <= 1'b0;
      aux_cnt_reg  <= 3'h0;
      aux_pin_out  <= 1'b0;
      aux_pin_oe   <= 1'b0;
    end else begin
      fod_prev_reg <= fod;
      if (fod & ~fod_prev_reg) begin
        aux_cnt_reg <= aux_cnt_reg + 3'h1;
      end
      // pin stays an input until the strap level has been latched
      if (!run) begin
        aux_pin_out <= 1'b0;
        aux_pin_oe  <= 1'b0;
      end else begin
        case (func_reg)
          `CGO_FUNC_LOW: begin
            aux_pin_out <= 1'b0;
            aux_pin_oe  <= 1'b1;
          end
          `CGO_FUNC_TRI: begin
            aux_pin_out <= 1'b0;
            aux_pin_oe  <= 1'b0;
          end
          `CGO_FUNC_AUX: begin
            aux_pin_out <= aux_clk;
            aux_pin_oe  <= 1'b1;
          end
          default: begin
            aux_pin_out <= clocks_ready;
            aux_pin_oe  <= 1'b1;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // enable pin pull resistors
  // ************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_pin_pullup   <= 1'b0;
      enable_pin_pulldown <= 1'b1;
      addr_pin_pullup     <= 1'b0;
      addr_pin_pulldown   <= 1'b0;
    end else begin
      enable_pin_pullup   <= ~pol_reg;
      enable_pin_pulldown <= pol_reg;
      // address pin is a strap unless split; then it pulls like the enable pin
      addr_pin_pullup     <= split_reg & ~pol_reg;
      addr_pin_pulldown   <= split_reg & pol_reg;
    end
  end

endmodule

/* pkg/cgo_defines.vh */
// constants for the clock output enable control block
// Operation
// - format 4 drives first, 5 second
// - format 6: both on, second inverted
// - format 7: both on, same phase
// - strap low serial mode, high page mode
// - aux clock: divider zero/one, then /2/4/8
// - pin function: low, tri, aux, valid
// - enable changes never truncate a clock pulse
// - pair enables at control bits 1, 8
// - polarity bit 1 active low, default
// - pull resistor follows polarity, float enables
// - split bit: address pin gates pair two
// - one polarity bit serves both pins
// - split bit loaded from page, writable
// - off state bit: 0 low, 1 tri-state
// - serial mode loads page zero
// - page defaults: enabled, in-phase, low, 25MHz
// - spread defaults: off, -0.1, -0.3, -0.5
// - page mode: page chosen by select pins
`ifndef CGO_DEFINES_VH
`define CGO_DEFINES_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define CGO_OFF_OFFSTATE 8'h0C
`define CGO_OFF_ENCTRL   8'h1C
`define CGO_OFF_SPLIT    8'h2C
`define CGO_OFF_FORMAT   8'h40
`define CGO_OFF_STATUS   8'h44

// ************************************************************
// field positions
// ************************************************************
`define CGO_B_ONE_OFF  5
`define CGO_B_TWO_OFF  6
`define CGO_B_POL      0
`define CGO_B_ONE_EN   1
`define CGO_B_TWO_EN   8
`define CGO_B_FUNC_HI  14
`define CGO_B_FUNC_LO  13
`define CGO_B_SPLIT    14
`define CGO_B_F1_HI    2
`define CGO_B_F1_LO    0
`define CGO_B_F2_HI    6
`define CGO_B_F2_LO    4
`define CGO_B_AUXSRC   8
`define CGO_B_AUXDIV_HI 10
`define CGO_B_AUXDIV_LO 9
`define CGO_B_SSCEN    12
`define CGO_B_SSCCFG_HI 15
`define CGO_B_SSCCFG_LO 13

// ************************************************************
// codes
// ************************************************************
`define CGO_FMT_A_ONLY 3'h4
`define CGO_FMT_B_ONLY 3'h5
`define CGO_FMT_ANTI   3'h6
`define CGO_FMT_SAME   3'h7
`define CGO_FUNC_LOW   2'h0
`define CGO_FUNC_TRI   2'h1
`define CGO_FUNC_AUX   2'h2
`define CGO_FUNC_READY 2'h3
`define CGO_DIV_2      2'h0
`define CGO_DIV_4      2'h1
`define CGO_DIV_8      2'h2

// ************************************************************
// reset values and page defaults
// ************************************************************
`define CGO_RST_POL    1'b1
`define CGO_RST_FUNC   2'h2
`define CGO_DEF_FMT    3'h7
`define CGO_DEF_EN     1'b1
`define CGO_DEF_OFF    1'b0
`define CGO_DEF_AUXSRC 1'b0
`define CGO_DEF_AUXDIV 2'h2
`define CGO_DEF_SPLIT  1'b0
`define CGO_SSC_EN_P0  1'b0
`define CGO_SSC_EN_PX  1'b1
`define CGO_SSC_CFG_P0 3'h0
`define CGO_SSC_CFG_P1 3'h1
`define CGO_SSC_CFG_P2 3'h3
`define CGO_SSC_CFG_P3 3'h4
`define CGO_SETTLE     2'h3

`endif

/* tb/cgo_checker.sv */
// port-level assertions for the clock output enable control block
`timescale 1ns/1ps
module cgo_checker (
  input wire       hclk,
  input wire       hresetn,
  input wire       hsel,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hready,
  input wire       hreadyout,
  input wire       hresp,
  input wire       pair_one_src,
  input wire       pair_two_src,
  input wire       aux_pin_oe,
  input wire       clock_out_a,
  input wire       clock_out_a_oe,
  input wire       clock_out_c,
  input wire       enable_pin_pullup,
  input wire       enable_pin_pulldown
);
  // **********
  // bus and output relations
  // **********
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire acc_rd = hsel & htrans[1] & hready & !hwrite;
  wire acc_wr = hsel & htrans[1] & hready & hwrite;
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_write_no_wait: assert property (acc_wr |=> hreadyout) else $error("write stalled");
  a_read_one_wait: assert property (acc_rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rise_a_src: assert property ($rose(clock_out_a) |-> $past(pair_one_src))
    else $error("output a rose without its source");
  a_fall_a_low: assert property ($fell(clock_out_a) |-> !$past(pair_one_src))
    else $error("output a pulse cut short");
  a_fall_c_low: assert property ($fell(clock_out_c) |-> !$past(pair_two_src))
    else $error("output c pulse cut short");
  a_pull_one_on: assert property (enable_pin_pullup != enable_pin_pulldown)
    else $error("enable pulls not exclusive");
  a_off_out_low: assert property (!clock_out_a_oe |-> !clock_out_a)
    else $error("output a high while released");
  a_strap_first: assert property ($rose(hresetn) |-> !aux_pin_oe [*4])
    else $error("strap pin driven before start-up");
  a_quiet_start: assert property ($rose(hresetn) |-> !clock_out_a [*4])
    else $error("output a ran before start-up");
  c_read: cover property (acc_rd);
  c_out_a: cover property ($rose(clock_out_a));
  c_aux_drive: cover property ($rose(aux_pin_oe));
endmodule

bind cgo_top cgo_checker u_chk (.*);

/* tb/cgo_far_side.sv */
// far-side model: divider and channel clock levels, enable pin with pulls
`timescale 1ns/1ps
module cgo_far_side (
  input  wire       hclk,
  input  wire [1:0] en_cmd,
  input  wire       pull_up,
  input  wire       pull_dn,
  output wire       src_fast,
  output wire       src_slow,
  output wire       en_lvl
);
  // **********
  // sources and pin
  // **********
  reg [1:0] cnt_reg = 2'h0;
  reg       float_reg = 1'b0;
  always @(posedge hclk) begin
    cnt_reg <= cnt_reg + 2'h1;
    float_reg <= ~float_reg;
  end
  // en_cmd 2 leaves the pin open; without a pull it wanders every cycle
  assign en_lvl = (en_cmd != 2'h2) ? en_cmd[0] :
                  pull_up ? 1'b1 : pull_dn ? 1'b0 : float_reg;
  assign src_fast = cnt_reg[0];
  assign src_slow = cnt_reg[1];
endmodule

/* tb/tb_clock_output_enable_control.sv */
// self-checking bench for the clock output enable control block
`timescale 1ns/1ps
`include "cgo_defines.vh"
module tb_clock_output_enable_control;
  // **********
  // signals
  // **********
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0;
  reg         clocks_ready = 1'b0;
  reg         addr_pin = 1'b0;
  reg  [1:0]  page_select_pins = 2'h0;
  reg         strap = 1'b0;
  reg  [1:0]  en_cmd = 2'h2;
  wire [31:0] hrdata;
  wire [2:0]  ssc_config;
  wire        hready, hreadyout, hresp, ssc_enable, enable_pin, aux_pin_in;
  wire        aux_pin_out, aux_pin_oe, pair_one_src, pair_two_src;
  wire        frac_divider_zero, frac_divider_one;
  wire        clock_out_a, clock_out_b, clock_out_c, clock_out_d;
  wire        clock_out_a_oe, clock_out_b_oe, clock_out_c_oe, clock_out_d_oe;
  wire        enable_pin_pullup, enable_pin_pulldown, addr_pin_pullup, addr_pin_pulldown;
  wire [3:0]  one_seen = {clock_out_a, clock_out_b, clock_out_a_oe, clock_out_b_oe};
  wire [3:0]  two_seen = {clock_out_c, clock_out_d, clock_out_c_oe, clock_out_d_oe};
  integer     n_fail = 0, comparisons = 0, cyc = 0, i, n, e, pg;
  reg  [31:0] rdata;
  reg         pol, s1, s2, sp, o1, o2, as, g1, g2, p1, p2, prv;
  reg  [2:0]  f1, f2;

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;
  // the strap resistor holds the pin whenever the block does not drive it
  assign aux_pin_in = aux_pin_oe ? aux_pin_out : strap;
  assign frac_divider_zero = pair_one_src;
  assign frac_divider_one = pair_two_src;

  cgo_top i_dut (.*);
  cgo_far_side i_far (.hclk(hclk), .en_cmd(en_cmd), .pull_up(enable_pin_pullup),
    .pull_dn(enable_pin_pulldown), .src_fast(pair_one_src), .src_slow(pair_two_src),
    .en_lvl(enable_pin));

  // **********
  // helpers
  // **********
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end

  task chk(input string nm, input [31:0] ex, input [31:0] got);
    comparisons = comparisons + 1;
    if (got !== ex) begin
      n_fail = n_fail + 1;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  // entered just after a rising edge; returns at the edge ending the address phase
  task addr_ph(input [7:0] a, input w);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
  endtask

  task wr(input [7:0] a, input [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task rd(input [7:0] a, output [31:0] d);
    addr_ph(a, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask

  task rc(input [7:0] a, input [31:0] m, input [31:0] ex);
    rd(a, rdata);
    chk("register", ex, rdata & m);
  endtask

  task do_reset(input s, input [1:0] p);
    hresetn <= 1'b0;
    strap <= s;
    page_select_pins <= p;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdata = 32'h0;
    while (rdata[3] !== 1'b1) rd(`CGO_OFF_STATUS, rdata);
  endtask

  // expected {first, second, first_oe, second_oe} of a pair
  function [3:0] pr(input [2:0] f, input g, input s, input off);
    reg ea, eb;
    begin
      ea = g & f[2] & (f != 3'h5);
      eb = g & f[2] & (f != 3'h4);
      pr = {ea & s, eb & (s ^ (f == 3'h6)), ea | ~off, eb | ~off};
    end
  endfunction

  // **********
  // scenarios
  // **********
  initial begin
    n = $urandom(66);
    for (i = 0; i < 5; i = i + 1) begin
      do_reset(i < 4, (i < 4) ? i[1:0] : 2'h3);
      pg = (i < 4) ? i : 0;
      chk("status", {pg[1:0], i < 4}, rdata[2:0]);
      chk("ssc_enable", pg != 0, ssc_enable);
      chk("ssc_config", (pg > 1) ? pg + 1 : pg, ssc_config);
    end
    rc(`CGO_OFF_ENCTRL, 32'h6103, 32'h4103);
    rc(`CGO_OFF_FORMAT, 32'h07FF, 32'h0477);
    rc(`CGO_OFF_OFFSTATE, 32'h0060, 32'h0000);
    rc(`CGO_OFF_SPLIT, 32'h4000, 32'h0000);
    wr(`CGO_OFF_SPLIT, 32'h4000);
    rc(`CGO_OFF_SPLIT, 32'h4000, 32'h4000);
    rc(8'h80, 32'hFFFFFFFF, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      clocks_ready <= 1'($urandom);
      wr(`CGO_OFF_ENCTRL, 32'h0103 | (i << 13));
      repeat (4) @(posedge hclk);
      chk("aux_pin_oe", i != 1, aux_pin_oe);
      if (i == 0 || i == 3) chk("aux_pin_out", (i == 3) & clocks_ready, aux_pin_out);
    end
    wr(`CGO_OFF_ENCTRL, 32'h4103);
    for (i = 0; i < 6; i = i + 1) begin
      wr(`CGO_OFF_FORMAT, 32'h77 | ((i % 3) << 9) | ((i / 3) << 8));
      repeat (8) @(posedge hclk);
      n = 0;
      prv = aux_pin_out;
      repeat (64) begin
        @(posedge hclk);
        if (aux_pin_out && !prv) n = n + 1;
        prv = aux_pin_out;
      end
      e = 64 / ((2 << (i % 3)) * (2 << (i / 3)));
      chk("aux_edges", 1, (n >= e - 1) && (n <= e + 1));
    end
    for (i = 0; i < 32; i = i + 1) begin
      {pol, s1, s2, sp, o1, o2} = 6'($urandom);
      en_cmd <= 2'($urandom % 3);
      addr_pin <= 1'($urandom);
      f1 = i[2:0];
      f2 = 3'(i + 3);
      wr(`CGO_OFF_OFFSTATE, {o2, o1, 5'h0});
      wr(`CGO_OFF_SPLIT, {sp, 14'h0});
      wr(`CGO_OFF_FORMAT, {f2, 1'b0, f1} | 32'h400);
      wr(`CGO_OFF_ENCTRL, 32'h4000 | (s2 << 8) | (s1 << 1) | pol);
      repeat (12) @(posedge hclk);
      chk("pulls", {!pol, pol}, {enable_pin_pullup, enable_pin_pulldown});
      chk("addr_pulls", {sp & !pol, sp & pol}, {addr_pin_pullup, addr_pin_pulldown});
      as = (en_cmd == 2'h2) || (en_cmd[0] != pol);
      g1 = s1 & as;
      g2 = s2 & (sp ? addr_pin != pol : as);
      p1 = pair_one_src;
      p2 = pair_two_src;
      repeat (8) begin
        @(posedge hclk);
        chk("pair_one", pr(f1, g1, p1, o1), one_seen);
        chk("pair_two", pr(f2, g2, p2, o2), two_seen);
        p1 = pair_one_src;
        p2 = pair_two_src;
      end
      rd(`CGO_OFF_STATUS, rdata);
      chk("running", {g2 & f2[2], g1 & f1[2]}, rdata[5:4]);
    end
    report_and_stop;
  end
endmodule
